// >>> verilog/bth_header_regs.sv
`timescale 1ns/1ps
// Behaviour
// - Cache line size byte is read/write, resets zero, affects nothing.
// - Primary latency timer reads zero; writes ignored.
// - Header type byte reads fixed one.
// - Self-test byte reads zero.
// - Both 32-bit base address words read zero, read-only.
// - Upstream bus number byte read/write, resets zero.
// - Downstream bus number byte read/write, resets zero.
// - Highest behind-bus number byte read/write, resets zero.
// - Secondary latency timer reads zero.
// - IO base bit 0 gives IO width capability, default one.
// - IO limit bit 0 mirrors the capability bit, read-only.
// - IO base bits 7:4 read/write, reset 0xf, address 15:12.
// - IO limit bits 7:4 read/write, reset zero, low bits all ones.
// - Base and limit together decide IO forwarding.
module bth_header_regs (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             io_width_capability,
    output logic             io_probe_forward,
    output logic [7:0]       upstream_bus_number,
    output logic [7:0]       downstream_bus_number,
    output logic [7:0]       highest_behind_bus_number
);
    logic [7:0]  cache_line_size;
    logic [3:0]  io_window_low;
    logic [3:0]  io_window_high;
    logic        cap_locked;
    logic [15:0] io_probe_addr;
    logic        wr_en;
    logic        rd_en;
    logic        addr_hit;
    logic [31:0] next_rdata;

    function automatic logic in_window(input logic [15:0] a, input logic [3:0] lo,
                                       input logic [3:0] hi);
        in_window = (a[15:12] >= lo) && (a[15:12] <= hi);
    endfunction

    function automatic logic lane_wr(input logic [11:0] a, input logic [11:0] reg_a,
                                     input logic [3:0] strb, input int lane);
        lane_wr = (a == reg_a) && strb[lane];
    endfunction

    // Byte register placed in the low lane of its word
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h00_0000, b};
    endfunction

    // IO window byte: field in the high nibble, capability in bit 0
    function automatic logic [31:0] io_field_word(input logic [3:0] field,
                                                  input logic       cap);
        io_field_word = byte_word({field, 3'h0, cap});
    endfunction

    // Every word that answers without an error
    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            bth_pkg::ADDR_CACHE_LINE,
            bth_pkg::ADDR_PRI_LATENCY,
            bth_pkg::ADDR_HEADER_TYPE,
            bth_pkg::ADDR_SELF_TEST,
            bth_pkg::ADDR_WINDOW_ZERO,
            bth_pkg::ADDR_WINDOW_ONE,
            bth_pkg::ADDR_UP_BUS,
            bth_pkg::ADDR_DOWN_BUS,
            bth_pkg::ADDR_HIGH_BUS,
            bth_pkg::ADDR_SEC_LATENCY,
            bth_pkg::ADDR_IO_LOW,
            bth_pkg::ADDR_IO_HIGH,
            bth_pkg::ADDR_SEC_STATUS,
            bth_pkg::ADDR_CAP_CTRL,
            bth_pkg::ADDR_IO_PROBE: begin
                is_mapped = 1'b1;
            end
            default: begin
                is_mapped = 1'b0;
            end
        endcase
    endfunction

    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && !pwrite;
    assign pready  = 1'b1;
    // unmapped words answer with an error
    assign addr_hit = is_mapped(paddr);
    assign pslverr = psel && penable && !addr_hit;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cache_line_size <= bth_pkg::CLS_RESET;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_CACHE_LINE, pstrb, 0)) begin
            cache_line_size <= pwdata[bth_pkg::LANE0_LSB +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            upstream_bus_number <= bth_pkg::BUS_RESET;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_UP_BUS, pstrb, 0)) begin
            upstream_bus_number <= pwdata[bth_pkg::LANE0_LSB +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            downstream_bus_number <= bth_pkg::BUS_RESET;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_DOWN_BUS, pstrb, 0)) begin
            downstream_bus_number <= pwdata[bth_pkg::LANE0_LSB +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            highest_behind_bus_number <= bth_pkg::BUS_RESET;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_HIGH_BUS, pstrb, 0)) begin
            highest_behind_bus_number <= pwdata[bth_pkg::LANE0_LSB +: 8];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_window_low <= bth_pkg::IO_LOW_RESET;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_IO_LOW, pstrb, 0)) begin
            io_window_low <= pwdata[bth_pkg::LANE0_LSB + bth_pkg::NIB_HI +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_window_high <= bth_pkg::IO_HIGH_RESET;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_IO_HIGH, pstrb, 0)) begin
            io_window_high <= pwdata[bth_pkg::LANE0_LSB + bth_pkg::NIB_HI +: 4];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_width_capability <= bth_pkg::IO_CAP_RESET;
        end else if (wr_en && !cap_locked &&
                     lane_wr(paddr, bth_pkg::ADDR_IO_LOW, pstrb, 0)) begin
            io_width_capability <= pwdata[bth_pkg::LANE0_LSB];
        end
    end

    // Lock bit is sticky until reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap_locked <= 1'b0;
        end else if (wr_en && lane_wr(paddr, bth_pkg::ADDR_CAP_CTRL, pstrb, 0) &&
                     pwdata[bth_pkg::LANE0_LSB]) begin
            cap_locked <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_probe_addr <= bth_pkg::PROBE_RESET;
        end else if (wr_en && (paddr == bth_pkg::ADDR_IO_PROBE)) begin
            if (pstrb[0]) begin
                io_probe_addr[7:0] <= pwdata[bth_pkg::LANE0_LSB +: 8];
            end
            if (pstrb[1]) begin
                io_probe_addr[15:8] <= pwdata[bth_pkg::LANE1_LSB +: 8];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_probe_forward <= 1'b0;
        end else begin
            io_probe_forward <= in_window(io_probe_addr, io_window_low, io_window_high);
        end
    end

    always_comb begin
        next_rdata = bth_pkg::ZERO_WORD;
        case (paddr)
            bth_pkg::ADDR_CACHE_LINE: begin
                next_rdata = byte_word(cache_line_size);
            end
            bth_pkg::ADDR_HEADER_TYPE: begin
                next_rdata = byte_word(bth_pkg::HEADER_TYPE_VALUE);
            end
            bth_pkg::ADDR_PRI_LATENCY,
            bth_pkg::ADDR_SELF_TEST,
            bth_pkg::ADDR_WINDOW_ZERO,
            bth_pkg::ADDR_WINDOW_ONE,
            bth_pkg::ADDR_SEC_LATENCY,
            bth_pkg::ADDR_SEC_STATUS: begin
                next_rdata = byte_word(bth_pkg::ZERO_BYTE);
            end
            bth_pkg::ADDR_UP_BUS: begin
                next_rdata = byte_word(upstream_bus_number);
            end
            bth_pkg::ADDR_DOWN_BUS: begin
                next_rdata = byte_word(downstream_bus_number);
            end
            bth_pkg::ADDR_HIGH_BUS: begin
                next_rdata = byte_word(highest_behind_bus_number);
            end
            bth_pkg::ADDR_IO_LOW: begin
                next_rdata = io_field_word(io_window_low, io_width_capability);
            end
            bth_pkg::ADDR_IO_HIGH: begin
                next_rdata = io_field_word(io_window_high, io_width_capability);
            end
            bth_pkg::ADDR_CAP_CTRL: begin
                next_rdata = byte_word({7'h00, cap_locked});
            end
            bth_pkg::ADDR_IO_PROBE: begin
                next_rdata = {15'h0000, io_probe_forward, io_probe_addr};
            end
            default: begin
                next_rdata = bth_pkg::ZERO_WORD;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= bth_pkg::ZERO_WORD;
        end else if (rd_en && !penable) begin
            prdata <= next_rdata;
        end
    end

    a_cls_write_held: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == bth_pkg::ADDR_CACHE_LINE && pstrb[0]
        |=> cache_line_size == $past(pwdata[7:0]))
        else $error("cache line size not stored");

    a_pri_latency_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == bth_pkg::ADDR_PRI_LATENCY
        |-> prdata == bth_pkg::ZERO_WORD)
        else $error("primary latency not zero");

    a_header_type_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == bth_pkg::ADDR_HEADER_TYPE
        |-> prdata == {24'h00_0000, bth_pkg::HEADER_TYPE_VALUE})
        else $error("header type wrong");

    a_self_test_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == bth_pkg::ADDR_SELF_TEST
        |-> prdata == bth_pkg::ZERO_WORD)
        else $error("self-test byte not zero");

    a_window_words_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite &&
        (paddr == bth_pkg::ADDR_WINDOW_ZERO || paddr == bth_pkg::ADDR_WINDOW_ONE)
        |-> prdata == bth_pkg::ZERO_WORD)
        else $error("base word not zero");

    a_bus_up_store: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == bth_pkg::ADDR_UP_BUS && pstrb[0]
        |=> upstream_bus_number == $past(pwdata[7:0]))
        else $error("upstream bus not stored");

    a_bus_down_store: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == bth_pkg::ADDR_DOWN_BUS && pstrb[0]
        |=> downstream_bus_number == $past(pwdata[7:0]))
        else $error("downstream bus not stored");

    a_bus_high_store: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == bth_pkg::ADDR_HIGH_BUS && pstrb[0]
        |=> highest_behind_bus_number == $past(pwdata[7:0]))
        else $error("highest bus not stored");

    a_sec_latency_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == bth_pkg::ADDR_SEC_LATENCY
        |-> prdata == bth_pkg::ZERO_WORD)
        else $error("secondary latency not zero");

    a_cap_mirror_read: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == bth_pkg::ADDR_IO_HIGH
        |-> prdata[0] == io_width_capability && prdata[3:1] == 3'h0 &&
            prdata[31:8] == 24'h00_0000)
        else $error("capability mirror wrong");

    a_cap_locked_hold: assert property (@(posedge pclk) disable iff (!presetn)
        cap_locked |=> $stable(io_width_capability))
        else $error("capability changed while locked");

    a_cap_open_store: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && !cap_locked && paddr == bth_pkg::ADDR_IO_LOW && pstrb[0]
        |=> io_width_capability == $past(pwdata[0]))
        else $error("capability not stored");

    a_io_low_store: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == bth_pkg::ADDR_IO_LOW && pstrb[0]
        |=> io_window_low == $past(pwdata[7:4]))
        else $error("IO base not stored");

    a_io_high_store: assert property (@(posedge pclk) disable iff (!presetn)
        wr_en && paddr == bth_pkg::ADDR_IO_HIGH && pstrb[0]
        |=> io_window_high == $past(pwdata[7:4]))
        else $error("IO limit not stored");

    a_forward_decide: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 io_probe_forward == ($past(io_probe_addr[15:12]) >= $past(io_window_low) &&
        $past(io_probe_addr[15:12]) <= $past(io_window_high)))
        else $error("forward decision wrong");

    a_empty_window: assert property (@(posedge pclk) disable iff (!presetn)
        io_window_low > io_window_high |=> !io_probe_forward)
        else $error("empty window forwarded");

    a_status_zero: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && paddr == bth_pkg::ADDR_SEC_STATUS
        |-> prdata == bth_pkg::ZERO_WORD && !pslverr)
        else $error("secondary status not zero");

    a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        psel && penable && !pwrite && !addr_hit
        |-> pslverr && prdata == bth_pkg::ZERO_WORD)
        else $error("unmapped access not flagged");

    a_lock_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        cap_locked |=> cap_locked)
        else $error("lock bit cleared");

    c_cls_write: cover property (@(posedge pclk) wr_en && paddr == bth_pkg::ADDR_CACHE_LINE);
    c_bus_write: cover property (@(posedge pclk) wr_en && paddr == bth_pkg::ADDR_UP_BUS);
    c_forward: cover property (@(posedge pclk) io_probe_forward);
    c_lock: cover property (@(posedge pclk) $rose(cap_locked));
    c_unmapped: cover property (@(posedge pclk) pslverr);
endmodule

// >>> verilog/bth_pkg.sv
package bth_pkg;
    // Register indices; each register owns the word at four times its index
    localparam logic [11:0] IDX_CACHE_LINE   = 12'h00c;
    localparam logic [11:0] IDX_PRI_LATENCY  = 12'h00d;
    localparam logic [11:0] IDX_HEADER_TYPE  = 12'h00e;
    localparam logic [11:0] IDX_SELF_TEST    = 12'h00f;
    localparam logic [11:0] IDX_WINDOW_ZERO  = 12'h010;
    localparam logic [11:0] IDX_WINDOW_ONE   = 12'h014;
    localparam logic [11:0] IDX_UP_BUS       = 12'h018;
    localparam logic [11:0] IDX_DOWN_BUS     = 12'h019;
    localparam logic [11:0] IDX_HIGH_BUS     = 12'h01a;
    localparam logic [11:0] IDX_SEC_LATENCY  = 12'h01b;
    localparam logic [11:0] IDX_IO_LOW       = 12'h01c;
    localparam logic [11:0] IDX_IO_HIGH      = 12'h01d;
    localparam logic [11:0] IDX_SEC_STATUS   = 12'h01e;
    // Extra words for the capability lock and probe address
    localparam logic [11:0] IDX_CAP_CTRL     = 12'h040;
    localparam logic [11:0] IDX_IO_PROBE     = 12'h044;

    // Byte addresses
    localparam logic [11:0] ADDR_CACHE_LINE  = {IDX_CACHE_LINE[9:0], 2'b00};
    localparam logic [11:0] ADDR_PRI_LATENCY = {IDX_PRI_LATENCY[9:0], 2'b00};
    localparam logic [11:0] ADDR_HEADER_TYPE = {IDX_HEADER_TYPE[9:0], 2'b00};
    localparam logic [11:0] ADDR_SELF_TEST   = {IDX_SELF_TEST[9:0], 2'b00};
    localparam logic [11:0] ADDR_WINDOW_ZERO = {IDX_WINDOW_ZERO[9:0], 2'b00};
    localparam logic [11:0] ADDR_WINDOW_ONE  = {IDX_WINDOW_ONE[9:0], 2'b00};
    localparam logic [11:0] ADDR_UP_BUS      = {IDX_UP_BUS[9:0], 2'b00};
    localparam logic [11:0] ADDR_DOWN_BUS    = {IDX_DOWN_BUS[9:0], 2'b00};
    localparam logic [11:0] ADDR_HIGH_BUS    = {IDX_HIGH_BUS[9:0], 2'b00};
    localparam logic [11:0] ADDR_SEC_LATENCY = {IDX_SEC_LATENCY[9:0], 2'b00};
    localparam logic [11:0] ADDR_IO_LOW      = {IDX_IO_LOW[9:0], 2'b00};
    localparam logic [11:0] ADDR_IO_HIGH     = {IDX_IO_HIGH[9:0], 2'b00};
    localparam logic [11:0] ADDR_SEC_STATUS  = {IDX_SEC_STATUS[9:0], 2'b00};
    localparam logic [11:0] ADDR_CAP_CTRL    = {IDX_CAP_CTRL[9:0], 2'b00};
    localparam logic [11:0] ADDR_IO_PROBE    = {IDX_IO_PROBE[9:0], 2'b00};

    localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
    localparam logic [15:0] PROBE_RESET      = 16'h0000;

    localparam logic [7:0] CLS_RESET         = 8'h00;
    localparam logic [7:0] HEADER_TYPE_VALUE = 8'h01;
    localparam logic [7:0] ZERO_BYTE         = 8'h00;
    localparam logic [7:0] BUS_RESET         = 8'h00;
    localparam logic [3:0] IO_LOW_RESET      = 4'hf;
    localparam logic [3:0] IO_HIGH_RESET     = 4'h0;
    localparam logic       IO_CAP_RESET      = 1'b1;

    // Byte lanes of a word
    localparam int LANE0_LSB = 0;
    localparam int LANE1_LSB = 8;
    localparam int LANE2_LSB = 16;
    localparam int LANE3_LSB = 24;
    localparam int NIB_HI    = 4;

    typedef enum logic [0:0] {
        BTH_SIXTEEN_BIT_IO    = 1'b0,
        BTH_THIRTY_TWO_BIT_IO = 1'b1
    } bth_io_width_t;
endpackage

// >>> dv/bth_header_regs_bench.sv
`timescale 1ns/1ps
module bth_header_regs_bench;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        io_width_capability;
    logic        io_probe_forward;
    logic [7:0]  upstream_bus_number;
    logic [7:0]  downstream_bus_number;
    logic [7:0]  highest_behind_bus_number;
    int          n_mismatch;
    int          compares;
    logic [31:0] rdata;
    logic        rerr;
    logic [15:0] probe_tab [7] = '{16'h1fff, 16'h2000, 16'h5fff, 16'h6000, 16'h3abc,
                                   16'h5000, 16'h6000};
    logic        fwd_tab [7]   = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

    bth_header_regs i_dut (
        .pclk                      (pclk),
        .presetn                   (presetn),
        .psel                      (psel),
        .penable                   (penable),
        .pwrite                    (pwrite),
        .paddr                     (paddr),
        .pwdata                    (pwdata),
        .pstrb                     (pstrb),
        .prdata                    (prdata),
        .pready                    (pready),
        .pslverr                   (pslverr),
        .io_width_capability       (io_width_capability),
        .io_probe_forward          (io_probe_forward),
        .upstream_bus_number       (upstream_bus_number),
        .downstream_bus_number     (downstream_bus_number),
        .highest_behind_bus_number (highest_behind_bus_number)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    // One APB transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        xfer(1'b1, a, d, s);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic err);
        xfer(1'b0, a, 32'h0, 4'h0);
        chk($sformatf("read data %h", a), exp, rdata);
        chk($sformatf("error flag %h", a), {31'h0, err}, {31'h0, rerr});
    endtask

    task automatic report_and_stop;
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        #(25 * 20000);
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        int k;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        n_mismatch = 0;
        compares = 0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(bth_pkg::ADDR_CACHE_LINE, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_PRI_LATENCY, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_HEADER_TYPE, 32'h1, 1'b0);
        rd(bth_pkg::ADDR_SELF_TEST, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_IO_LOW, 32'hf1, 1'b0);
        rd(bth_pkg::ADDR_IO_HIGH, 32'h01, 1'b0);
        chk("capability out", 32'h1, {31'h0, io_width_capability});
        wr(bth_pkg::ADDR_CACHE_LINE, 32'hffffffff, 4'hf);
        wr(bth_pkg::ADDR_PRI_LATENCY, 32'hffffffff, 4'hf);
        wr(bth_pkg::ADDR_HEADER_TYPE, 32'hffffffff, 4'hf);
        wr(bth_pkg::ADDR_SELF_TEST, 32'hffffffff, 4'hf);
        rd(bth_pkg::ADDR_CACHE_LINE, 32'hff, 1'b0);
        rd(bth_pkg::ADDR_PRI_LATENCY, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_HEADER_TYPE, 32'h1, 1'b0);
        rd(bth_pkg::ADDR_SELF_TEST, 32'h0, 1'b0);
        wr(bth_pkg::ADDR_WINDOW_ZERO, 32'hffffffff, 4'hf);
        wr(bth_pkg::ADDR_WINDOW_ONE, 32'hffffffff, 4'hf);
        rd(bth_pkg::ADDR_WINDOW_ZERO, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_WINDOW_ONE, 32'h0, 1'b0);
        wr(bth_pkg::ADDR_UP_BUS, 32'hffffff3c, 4'hf);
        wr(bth_pkg::ADDR_DOWN_BUS, 32'hffffffc3, 4'hf);
        wr(bth_pkg::ADDR_HIGH_BUS, 32'hffffffa5, 4'hf);
        wr(bth_pkg::ADDR_SEC_LATENCY, 32'hffffffff, 4'hf);
        wr(bth_pkg::ADDR_UP_BUS, 32'h00000011, 4'h1);
        wr(bth_pkg::ADDR_DOWN_BUS, 32'h00000077, 4'h0);
        rd(bth_pkg::ADDR_UP_BUS, 32'h11, 1'b0);
        rd(bth_pkg::ADDR_DOWN_BUS, 32'hc3, 1'b0);
        rd(bth_pkg::ADDR_HIGH_BUS, 32'ha5, 1'b0);
        rd(bth_pkg::ADDR_SEC_LATENCY, 32'h0, 1'b0);
        chk("bus outputs", 32'h00a5c311, {8'h0, highest_behind_bus_number,
            downstream_bus_number, upstream_bus_number});
        wr(bth_pkg::ADDR_IO_LOW, 32'hffffff2e, 4'hf);
        wr(bth_pkg::ADDR_IO_HIGH, 32'hffffff5f, 4'hf);
        rd(bth_pkg::ADDR_IO_LOW, 32'h20, 1'b0);
        rd(bth_pkg::ADDR_IO_HIGH, 32'h50, 1'b0);
        chk("capability out", 32'h0, {31'h0, io_width_capability});
        wr(bth_pkg::ADDR_SEC_STATUS, 32'hffffffff, 4'hf);
        rd(bth_pkg::ADDR_SEC_STATUS, 32'h0, 1'b0);
        // Window edges, then an empty window with base above limit
        for (k = 0; k < 7; k++) begin
            wr(bth_pkg::ADDR_IO_LOW, (k < 5) ? 32'h00000020 : 32'h00000060, 4'hf);
            wr(bth_pkg::ADDR_IO_PROBE, {16'h0, probe_tab[k]}, 4'hf);
            repeat (2) @(posedge pclk);
            chk($sformatf("forward %h", probe_tab[k]), {31'h0, fwd_tab[k]},
                {31'h0, io_probe_forward});
            rd(bth_pkg::ADDR_IO_PROBE, {15'h0, fwd_tab[k], probe_tab[k]}, 1'b0);
        end
        wr(bth_pkg::ADDR_CAP_CTRL, 32'h1, 4'hf);
        wr(bth_pkg::ADDR_IO_LOW, 32'h00000021, 4'hf);
        rd(bth_pkg::ADDR_IO_LOW, 32'h20, 1'b0);
        rd(bth_pkg::ADDR_IO_HIGH, 32'h50, 1'b0);
        rd(bth_pkg::ADDR_CAP_CTRL, 32'h1, 1'b0);
        wr(12'h080, 32'hffffffff, 4'hf);
        rd(12'h080, 32'h0, 1'b1);
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(bth_pkg::ADDR_CACHE_LINE, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_UP_BUS, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_DOWN_BUS, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_HIGH_BUS, 32'h0, 1'b0);
        rd(bth_pkg::ADDR_IO_LOW, 32'hf1, 1'b0);
        rd(bth_pkg::ADDR_IO_HIGH, 32'h01, 1'b0);
        rd(bth_pkg::ADDR_CAP_CTRL, 32'h0, 1'b0);
        report_and_stop();
    end
endmodule
